// ===== pkg/mbf_pkg.sv
// Purpose: Shared constants for the overhead bit flow configuration block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   All offsets are byte addresses
package mbf_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_IF = 2;
    localparam int IF_W = 1;
    localparam int ADDR_W = 8;
    localparam int CFG_W = 6;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_LINE_IF_SEL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_FLOW_CFG = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_MF_TX = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_LINE_MODE = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_BAC_PASS = 0;
    localparam int BIT_PAIR_INV = 1;
    localparam int BIT_QT_SRC = 2;
    localparam int BIT_FRAME_SRC = 3;
    localparam int BIT_QT_DST = 4;
    localparam int BIT_RX_FILL = 5;
    localparam int BIT_MF_TX_FIELD = 0;
    localparam int BIT_UP_S_TX = 6;
    localparam int BIT_MODE_UP = 0;
    localparam int BIT_CHAN_PICK = 1;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [CFG_W-1:0] RST_FLOW_CFG = 6'h00;
    localparam logic [1:0] RST_MF_TX = 2'h0;
    localparam logic [1:0] RST_LINE_MODE = 2'h0;
    localparam logic [IF_W-1:0] RST_LINE_IF_SEL = 1'h0;
endpackage : mbf_pkg

// ===== rtl/mbf_bit_map.sv
// Purpose: Overhead bit routing for one line interface
// Assumes: Frame-side inputs are synchronous to clk_i
// Notes:   All outputs registered, frozen while ce_i is low
`timescale 1ns/1ps
module mbf_bit_map (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Configuration
    input wire logic [mbf_pkg::CFG_W-1:0] cfg_i,
    input wire logic up_mode_i,
    input wire logic chan_pick_i,
    input wire logic mf_field_i,
    input wire logic up_s_tx_i,
    // Transmit sources
    input wire logic mfc_m_bit_i,
    input wire logic d_bac_i,
    input wire logic e_bac_i,
    input wire logic d_s_i,
    input wire logic e_s_i,
    // Receive overhead bit
    input wire logic rx_qt_i,
    // Results
    output logic tx_qt_o,
    output logic tx_ms_o,
    output logic rx_sg_o,
    output logic rx_ab_o,
    output logic [2:0] rx_fill_o
);
    import mbf_pkg::*;

    logic tx_qt_q, tx_qt_d;
    logic tx_ms_q, tx_ms_d;
    logic rx_sg_q, rx_sg_d;
    logic rx_ab_q, rx_ab_d;
    logic [2:0] rx_fill_q, rx_fill_d;
    logic bac_sel;
    logic ch_ms;
    logic rx_val;

    always_comb begin
        // Channel pick: low takes D-channel, high takes E-channel
        bac_sel = chan_pick_i ? e_bac_i : d_bac_i;
        ch_ms = chan_pick_i ? e_s_i : d_s_i;
        bac_sel = bac_sel ^ ~cfg_i[BIT_BAC_PASS];
        tx_qt_d = cfg_i[BIT_QT_SRC] ? bac_sel : mf_field_i;
        if (up_mode_i) begin
            // Stored S bit only matters in Up mode
            tx_ms_d = cfg_i[BIT_FRAME_SRC] ? ch_ms : up_s_tx_i;
        end else begin
            tx_ms_d = cfg_i[BIT_FRAME_SRC] ? ch_ms : mfc_m_bit_i;
        end
        rx_val = rx_qt_i ^ cfg_i[BIT_PAIR_INV];
        // Unselected position reads as one
        rx_sg_d = cfg_i[BIT_QT_DST] ? 1'b1 : rx_val;
        rx_ab_d = cfg_i[BIT_QT_DST] ? rx_val : 1'b1;
        rx_fill_d = {3{cfg_i[BIT_RX_FILL]}};
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_qt_q <= 1'b0;
            tx_ms_q <= 1'b0;
            rx_sg_q <= 1'b1;
            rx_ab_q <= 1'b1;
            rx_fill_q <= 3'h0;
        end else if (ce_i) begin
            tx_qt_q <= tx_qt_d;
            tx_ms_q <= tx_ms_d;
            rx_sg_q <= rx_sg_d;
            rx_ab_q <= rx_ab_d;
            rx_fill_q <= rx_fill_d;
        end
    end

    assign tx_qt_o = tx_qt_q;
    assign tx_ms_o = tx_ms_q;
    assign rx_sg_o = rx_sg_q;
    assign rx_ab_o = rx_ab_q;
    assign rx_fill_o = rx_fill_q;
endmodule : mbf_bit_map

// ===== rtl/mbf_top.sv
// Purpose: APB-configured multiframe/superframe overhead bit flow for line interfaces
// Assumes: One clock, APB master per AMBA APB4 signalling
// Notes:   Per-interface registers are reached through the line interface select
//
// Behaviour
// - Clear bit 0 inverts the BAC bit; set passes it unchanged.
// - Bit 1 set inverts the received S/G or A/B destination bit.
// - Bit 2 picks transmitted S/Q/T source: multiframe field or channel BAC.
// - S/T mode, bit 3 picks M bit: frame controller or D/E channel.
// - Up mode, bit 3 picks S bit: stored Up S field or D/E channel.
// - Bit 4 stores received S/Q/T bits as S/G (clear) or A/B (set).
// - The unselected S/G or A/B position always reads one.
// - Unused received bits 3 to 1 take the value of bit 5.
// - Stored Up S bit feeds transmission only in Up mode.
// - Per-interface mode bit selects S/T or Up; change only after reset (a later write still takes effect here).
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
module mbf_top (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [mbf_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Frame-side sources, one bit per interface
    input wire logic [mbf_pkg::NUM_IF-1:0] mfc_m_bit_i,
    input wire logic [mbf_pkg::NUM_IF-1:0] d_bac_i,
    input wire logic [mbf_pkg::NUM_IF-1:0] e_bac_i,
    input wire logic [mbf_pkg::NUM_IF-1:0] d_s_i,
    input wire logic [mbf_pkg::NUM_IF-1:0] e_s_i,
    input wire logic [mbf_pkg::NUM_IF-1:0] rx_qt_i,
    // Routed overhead bits, one per interface, three fill bits per interface
    output logic [mbf_pkg::NUM_IF-1:0] tx_qt_o,
    output logic [mbf_pkg::NUM_IF-1:0] tx_ms_o,
    output logic [mbf_pkg::NUM_IF-1:0] rx_sg_o,
    output logic [mbf_pkg::NUM_IF-1:0] rx_ab_o,
    output logic [3*mbf_pkg::NUM_IF-1:0] rx_fill_o
);
    import mbf_pkg::*;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [IF_W-1:0] sel_q, sel_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic acc;
    logic wr;
    logic hit;
    logic [5:0] status_word;
    wire [NUM_IF-1:0] mode_up_w;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    // First access cycle opens the transfer, the wait-state cycle closes it
    always_comb begin
        acc = psel_i && penable_i && !pready_q;
        // Commit only on the closing edge, so a refused transfer never writes
        wr = psel_i && penable_i && pready_q && pwrite_i && !pslverr_q && pstrb_i[0];
        hit = (paddr_i == OFS_LINE_IF_SEL) || (paddr_i == OFS_FLOW_CFG) ||
              (paddr_i == OFS_MF_TX) || (paddr_i == OFS_LINE_MODE) ||
              ((paddr_i == OFS_STATUS) && !pwrite_i);
    end

    // Status shows the selected interface only, like every per-interface register
    always_comb begin
        status_word = {rx_fill_o[3*sel_q], rx_ab_o[sel_q], rx_sg_o[sel_q],
                       tx_ms_o[sel_q], tx_qt_o[sel_q], mode_up_w[sel_q]};
    end

    // ------------------------------------------------------------
    // APB response, one wait state so every output is registered
    // ------------------------------------------------------------
    always_comb begin
        pready_d = acc;
        pslverr_d = acc && !hit;
        // Idle and write cycles return zero on the read bus
        prdata_d = 32'h0;
        if (acc && !pwrite_i) begin
            case (paddr_i)
                OFS_LINE_IF_SEL: prdata_d = {{(32-IF_W){1'b0}}, sel_q};
                OFS_STATUS: prdata_d = {26'h0, status_word};
                default: prdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_q <= 32'h0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else if (ce_i) begin
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;

    // ------------------------------------------------------------
    // Line interface select
    // ------------------------------------------------------------
    // A new selection steers per-interface writes from the next transfer on
    always_comb begin
        sel_d = sel_q;
        if (wr && (paddr_i == OFS_LINE_IF_SEL)) begin
            sel_d = pwdata_i[IF_W-1:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sel_q <= RST_LINE_IF_SEL;
        end else if (ce_i) begin
            sel_q <= sel_d;
        end
    end

    // ------------------------------------------------------------
    // Per-interface settings and bit routing
    // ------------------------------------------------------------
    for (genvar g = 0; g < NUM_IF; g++) begin : g_if
        localparam logic [IF_W-1:0] IF_IDX = IF_W'(g);
        logic [CFG_W-1:0] cfg_q, cfg_d;
        logic [1:0] mf_q, mf_d;
        logic [1:0] mode_q, mode_d;
        logic wr_here;

        always_comb begin
            // Writes land in the interface chosen beforehand
            wr_here = wr && (sel_q == IF_IDX);
            cfg_d = cfg_q;
            mf_d = mf_q;
            mode_d = mode_q;
            if (wr_here && (paddr_i == OFS_FLOW_CFG)) begin
                // Reserved upper bits are dropped here
                cfg_d = pwdata_i[CFG_W-1:0];
            end
            if (wr_here && (paddr_i == OFS_MF_TX)) begin
                mf_d = {pwdata_i[BIT_UP_S_TX], pwdata_i[BIT_MF_TX_FIELD]};
            end
            if (wr_here && (paddr_i == OFS_LINE_MODE)) begin
                // Meant to be set once after reset; a later write still lands
                mode_d = {pwdata_i[BIT_CHAN_PICK], pwdata_i[BIT_MODE_UP]};
            end
        end

        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                cfg_q <= RST_FLOW_CFG;
                mf_q <= RST_MF_TX;
                mode_q <= RST_LINE_MODE;
            end else if (ce_i) begin
                cfg_q <= cfg_d;
                mf_q <= mf_d;
                mode_q <= mode_d;
            end
        end

        assign mode_up_w[g] = mode_q[BIT_MODE_UP];

        mbf_bit_map u_map (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .ce_i(ce_i),
            .cfg_i(cfg_q),
            .up_mode_i(mode_q[BIT_MODE_UP]),
            .chan_pick_i(mode_q[1]),
            .mf_field_i(mf_q[0]),
            .up_s_tx_i(mf_q[1]),
            .mfc_m_bit_i(mfc_m_bit_i[g]),
            .d_bac_i(d_bac_i[g]),
            .e_bac_i(e_bac_i[g]),
            .d_s_i(d_s_i[g]),
            .e_s_i(e_s_i[g]),
            .rx_qt_i(rx_qt_i[g]),
            .tx_qt_o(tx_qt_o[g]),
            .tx_ms_o(tx_ms_o[g]),
            .rx_sg_o(rx_sg_o[g]),
            .rx_ab_o(rx_ab_o[g]),
            .rx_fill_o(rx_fill_o[3*g +: 3])
        );
    end
endmodule : mbf_top

// ===== bench/mbf_checker.sv
// Purpose: Port checks of the APB slave and receive placement
// Assumes: ce_i high while an APB transfer runs
// Notes:   Config is not visible here; routing is judged by the bench
`timescale 1ns/1ps
module mbf_checker (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // APB
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [mbf_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Receive positions
    input wire logic [mbf_pkg::NUM_IF-1:0] rx_sg_o,
    input wire logic [mbf_pkg::NUM_IF-1:0] rx_ab_o,
    input wire logic [3*mbf_pkg::NUM_IF-1:0] rx_fill_o
);
    import mbf_pkg::*;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    wire acc = psel_i && penable_i && !pready_o;
    property p_wait; acc |=> pready_o; endproperty
    property p_pulse; pready_o |=> !pready_o; endproperty
    property p_cause; !(psel_i && penable_i) |=> !pready_o; endproperty
    property p_err; pslverr_o |-> pready_o; endproperty
    property p_idle; !pready_o |-> prdata_o == 32'h0; endproperty
    property p_bad; acc && (paddr_i > OFS_STATUS || (pwrite_i && paddr_i == OFS_STATUS))
        |=> pslverr_o; endproperty
    property p_good; acc && paddr_i == OFS_FLOW_CFG |=> !pslverr_o; endproperty
    property p_one; &(rx_sg_o | rx_ab_o); endproperty
    property p_fill; rx_fill_o[2:0] inside {3'h0, 3'h7} && rx_fill_o[5:3] inside {3'h0, 3'h7};
    endproperty
    a_wait: assert property (p_wait) else $error("no ready after access");
    a_pulse: assert property (p_pulse) else $error("ready too long");
    a_cause: assert property (p_cause) else $error("ready without access");
    a_err: assert property (p_err) else $error("error without ready");
    a_idle: assert property (p_idle) else $error("read data not zero");
    a_bad: assert property (p_bad) else $error("bad access not refused");
    a_good: assert property (p_good) else $error("good access refused");
    a_one: assert property (p_one) else $error("spare position not one");
    a_fill: assert property (p_fill) else $error("fill bits differ");
    c_wr: cover property (acc && pwrite_i);
    c_rd: cover property (acc && !pwrite_i);
    c_err: cover property (pslverr_o);
endmodule : mbf_checker
bind mbf_top mbf_checker mbf_checker_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .rx_sg_o(rx_sg_o), .rx_ab_o(rx_ab_o),
    .rx_fill_o(rx_fill_o));

// ===== bench/mbf_line_model.sv
// Purpose: Far-side framer model feeding overhead bits
// Assumes: Bench changes pattern at a rising edge
// Notes:   Bits held a whole slot, as the framer does
`timescale 1ns/1ps
module mbf_line_model (
    // Pattern
    input wire logic [11:0] pat_i,
    // Frame-side bits
    output logic [mbf_pkg::NUM_IF-1:0] m_o,
    output logic [mbf_pkg::NUM_IF-1:0] db_o,
    output logic [mbf_pkg::NUM_IF-1:0] eb_o,
    output logic [mbf_pkg::NUM_IF-1:0] ds_o,
    output logic [mbf_pkg::NUM_IF-1:0] es_o,
    output logic [mbf_pkg::NUM_IF-1:0] rq_o
);
    import mbf_pkg::*;
    assign {rq_o, es_o, ds_o, eb_o, db_o, m_o} = pat_i;
endmodule : mbf_line_model

// ===== bench/mbf_top_tb.sv
// Purpose: Self-checking bench of the overhead bit routing
// Assumes: Two interfaces, pstrb_i tied, ce_i lowered only while the bus is idle
// Notes:   Expected routing rebuilt from a shadow of the writes
`timescale 1ns/1ps
module mbf_top_tb;
    import mbf_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, prdy, perr, sel = 1'b0;
    logic [7:0] pa = 8'h0;
    logic [31:0] pwd = 32'h0, prd, r;
    logic [11:0] pat = 12'h0;
    logic [1:0] m, db, eb, ds, es, rq, tq, tm, sg, ab, up, pk, mf, us;
    logic [5:0] fl, cfg [2];
    logic e;
    logic ce = 1'b1;
    int mismatches = 0, checked = 0;
    always #5 clk_i = ~clk_i;
    mbf_top mbf_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .pstrb_i(4'hf),
        .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr), .mfc_m_bit_i(m), .d_bac_i(db),
        .e_bac_i(eb), .d_s_i(ds), .e_s_i(es), .rx_qt_i(rq), .tx_qt_o(tq), .tx_ms_o(tm),
        .rx_sg_o(sg), .rx_ab_o(ab), .rx_fill_o(fl));
    mbf_line_model mbf_line_model_i (.pat_i(pat), .m_o(m), .db_o(db), .eb_o(eb), .ds_o(ds),
        .es_o(es), .rq_o(rq));
    task tally_and_finish();
        if (mismatches == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish
    task cmp(input logic ok, input string s);
        checked++;
        if (!ok) begin
            mismatches++;
            $display("unexpected at %0t: %s", $time, s);
        end
    endtask : cmp
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk_i);
        pen <= 1'b1;
        // Request stands until pready is sampled high at a rising edge
        do begin
            @(posedge clk_i);
            n++;
        end while (prdy !== 1'b1 && n < 20);
        r = prd;
        e = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        cmp(n < 20, "no ready");
    endtask : apb
    // Shadow of the per-interface settings, reached through the select
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        cmp(e === 1'b0, "write refused");
        case (a)
            8'h00: sel = d[0];
            8'h04: cfg[sel] = d[5:0];
            8'h08: {mf[sel], us[sel]} = {d[0], d[6]};
            8'h0c: {up[sel], pk[sel]} = {d[0], d[1]};
            default: ;
        endcase
    endtask : wr
    function automatic logic [6:0] ex(input int g, input logic [11:0] p);
        logic b, s, q;
        b = pk[g] ? p[4+g] : p[2+g];
        b = cfg[g][0] ? b : ~b;
        s = cfg[g][3] ? (pk[g] ? p[8+g] : p[6+g]) : (up[g] ? us[g] : p[g]);
        q = p[10+g] ^ cfg[g][1];
        return {cfg[g][2] ? b : mf[g], s, cfg[g][4] | q, ~cfg[g][4] | q, {3{cfg[g][5]}}};
    endfunction : ex
    task chk();
        for (int i = 0; i < 2; i++) begin
            pat <= i ? 12'ha5c : 12'h5a3;
            repeat (3) @(posedge clk_i);
            for (int g = 0; g < 2; g++) begin
                cmp({tq[g], tm[g], sg[g], ab[g], fl[3*g+:3]} === ex(g, pat), "routing");
            end
        end
    endtask : chk
    task t_tx();
        wr(8'h04, 32'h04);
        chk();
        wr(8'h0c, 32'h02);
        wr(8'h04, 32'h05);
        chk();
        wr(8'h08, 32'h41);
        wr(8'h04, 32'h08);
        chk();
    endtask : t_tx
    task t_up();
        wr(8'h00, 32'h01);
        wr(8'h0c, 32'h01);
        wr(8'h08, 32'h40);
        chk();
        wr(8'h04, 32'h08);
        chk();
    endtask : t_up
    task t_rx();
        wr(8'h04, 32'h12);
        chk();
        wr(8'h04, 32'h22);
        chk();
    endtask : t_rx
    task t_ce();
        logic [13:0] o;
        o = {tq, tm, sg, ab, fl};
        ce <= 1'b0;
        pat <= ~pat;
        repeat (3) @(posedge clk_i);
        cmp({tq, tm, sg, ab, fl} === o, "outputs moved while disabled");
        ce <= 1'b1;
        chk();
    endtask : t_ce
    task t_bus();
        logic [6:0] x;
        apb(1'b0, 8'h20, 32'h0);
        cmp(e === 1'b1 && r === 32'h0, "unmapped read");
        apb(1'b1, OFS_STATUS, 32'h0);
        cmp(e === 1'b1, "status write");
        apb(1'b0, OFS_FLOW_CFG, 32'h0);
        cmp(e === 1'b0 && r === 32'h0, "write-only read");
        apb(1'b0, OFS_LINE_IF_SEL, 32'h0);
        cmp(r[0] === sel, "select readback");
        x = ex(sel, pat);
        apb(1'b0, OFS_STATUS, 32'h0);
        cmp(e === 1'b0 && r === {26'h0, x[0], x[3], x[4], x[5], x[6], up[sel]}, "status");
    endtask : t_bus
    initial begin
        {up, pk, mf, us} = '0;
        cfg = '{6'h0, 6'h0};
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        chk();
        t_tx();
        t_up();
        t_rx();
        t_ce();
        t_bus();
        tally_and_finish();
    end
    initial begin
        #100us;
        mismatches++;
        tally_and_finish();
    end
endmodule : mbf_top_tb
